/* File: core/brio_pkg.sv */
// Package of constants shared by the I/O window address decoder.
package brio_pkg;

	// ------------------------------------------------------------
	// Configuration space offsets (byte addresses; OFS_IO_LOW and OFS_IO_HIGH are dword aligned)
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_IO_LOW = 8'h1C;
	localparam logic [7:0] OFS_IO_HIGH = 8'h30;
	localparam logic [7:0] OFS_IO_BASE_LOW = 8'h1C;
	localparam logic [7:0] OFS_IO_LIMIT_LOW = 8'h1D;
	localparam logic [7:0] OFS_IO_BASE_HIGH = 8'h30;
	localparam logic [7:0] OFS_IO_LIMIT_HIGH = 8'h32;

	// ------------------------------------------------------------
	// Field layout and constant values
	// ------------------------------------------------------------
	localparam logic [3:0] IO_CAP_NIBBLE = 4'h1;
	localparam logic [11:0] IO_BASE_FILL = 12'h000;
	localparam logic [11:0] IO_LIMIT_FILL = 12'hFFF;
	localparam logic [3:0] IO_BASE_NIB_RESET = 4'h0;
	localparam logic [3:0] IO_LIMIT_NIB_RESET = 4'h0;
	localparam logic [15:0] IO_HIGH_RESET = 16'h0000;
	localparam logic [15:0] ISA_REGION_HIGH = 16'h0000;
	localparam logic [1:0] ISA_LOW_QUARTER = 2'h0;
	localparam int NIB_HI_MSB = 7;
	localparam int NIB_HI_LSB = 4;
	localparam int ISA_SEL_MSB = 9;
	localparam int ISA_SEL_LSB = 8;
	localparam logic [31:0] RD_ZERO = 32'h0000_0000;
	localparam logic [31:0] IO_RESET_LIMIT = 32'h0000_0FFF;

endpackage

/* File: core/brio_io_window.sv */
// Inclusive I/O window compare with the ISA-mode hole below 64 kB.
`timescale 1ns/10ps
`default_nettype none
module brio_io_window
	import brio_pkg::*;
(
	input wire logic [31:0] addr,
	input wire logic [31:0] windowBase,
	input wire logic [31:0] windowLimit,
	input wire logic isaEnable,
	output logic inWindow,
	output logic claimDown
);

	wire logic windowOn;
	wire logic firstSixtyFour;
	wire logic isaHole;

	// A base above the limit turns the window off entirely.
	assign windowOn = windowBase <= windowLimit;
	assign inWindow = windowOn && addr >= windowBase &&
		addr <= windowLimit;
	assign firstSixtyFour = addr[31:16] == ISA_REGION_HIGH;
	assign isaHole = isaEnable && firstSixtyFour &&
		addr[ISA_SEL_MSB:ISA_SEL_LSB] != ISA_LOW_QUARTER;
	assign claimDown = inWindow && !isaHole;

endmodule
`default_nettype wire

/* File: core/brio_decode.sv */
// I/O address decoder of a two-bus bridge with its window registers.
`timescale 1ns/10ps
`default_nettype none

// Function
// - Forward in-window primary I/O when enabled.
// - Forward out-of-window secondary I/O upstream.
// - I/O enable clear ignores primary I/O.
// - Master enable clear ignores secondary traffic.
// - Base above limit disables the window.
// - Base byte: bits 15:12, low nibble 1h.
// - Writable upper 16 base address bits.
// - Limit byte: bits 15:12, low nibble 1h.
// - Writable upper 16 limit address bits.
// - Reset window to 0000_0000h through 0000_0FFFh.
// - ISA mode acts only inside window below 64 kB.
// - ISA mode blocks upper 768 bytes of each 1 kB downstream.
// - ISA mode forwards those 768 bytes upstream.
// - Above 64 kB decode by window only.
// - Memory enable gates downstream memory forwarding.
// - Master enable permits upstream memory and I/O.
// - No translation; unclaimed addresses go upstream.
module brio_decode
	import brio_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	// Configuration access from the primary side.
	input wire logic cfgWrite,
	input wire logic cfgRead,
	input wire logic [7:0] cfgAddr,
	input wire logic [3:0] cfgByteEn,
	input wire logic [31:0] cfgWrData,
	output logic [31:0] cfgRdData_q,
	output logic cfgRdValid_q,
	// Command and bridge control bits held elsewhere.
	input wire logic ioEnable,
	input wire logic memEnable,
	input wire logic masterEnable,
	input wire logic isaEnable,
	// Primary bus transaction presented for decode.
	input wire logic priValid,
	input wire logic priIsIo,
	input wire logic priIsMem,
	input wire logic [31:0] priAddr,
	input wire logic priMemHit,
	output logic priFwdIo_q,
	output logic priFwdMem_q,
	output logic [31:0] priFwdAddr_q,
	// Secondary bus transaction presented for decode.
	input wire logic secValid,
	input wire logic secIsIo,
	input wire logic secIsMem,
	input wire logic [31:0] secAddr,
	input wire logic secMemHit,
	output logic secFwdIo_q,
	output logic secFwdMem_q,
	output logic [31:0] secFwdAddr_q,
	// Window state for the memory and VGA decoders.
	output logic ioWindowOn_q
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [7:0] laneMerge(input logic [7:0] oldVal,
		input logic [7:0] newVal, input logic enable);
		laneMerge = enable ? newVal : oldVal;
	endfunction

	function automatic logic dwordHit(input logic [7:0] addr,
		input logic [7:0] ofs);
		dwordHit = addr[7:2] == ofs[7:2];
	endfunction

	// ------------------------------------------------------------
	// Window registers
	// ------------------------------------------------------------
	logic [3:0] baseNib_q;
	logic [3:0] baseNib_d;
	logic [3:0] limitNib_q;
	logic [3:0] limitNib_d;
	logic [15:0] baseHigh_q;
	logic [15:0] baseHigh_d;
	logic [15:0] limitHigh_q;
	logic [15:0] limitHigh_d;

	wire logic hitLow;
	wire logic hitHigh;
	wire logic wrLow;
	wire logic wrHigh;
	wire logic [7:0] baseLowByte;
	wire logic [7:0] limitLowByte;
	wire logic [7:0] baseLowNew;
	wire logic [7:0] limitLowNew;

	assign hitLow = dwordHit(cfgAddr, OFS_IO_LOW);
	assign hitHigh = dwordHit(cfgAddr, OFS_IO_HIGH);
	assign wrLow = cfgWrite && hitLow;
	assign wrHigh = cfgWrite && hitHigh;

	// Low nibble of each byte is a fixed capability code.
	assign baseLowByte = {baseNib_q, IO_CAP_NIBBLE};
	assign limitLowByte = {limitNib_q, IO_CAP_NIBBLE};

	assign baseLowNew = laneMerge(baseLowByte, cfgWrData[7:0],
		wrLow && cfgByteEn[0]);
	assign limitLowNew = laneMerge(limitLowByte, cfgWrData[15:8],
		wrLow && cfgByteEn[1]);

	assign baseNib_d = baseLowNew[NIB_HI_MSB:NIB_HI_LSB];
	assign limitNib_d = limitLowNew[NIB_HI_MSB:NIB_HI_LSB];
	assign baseHigh_d = {laneMerge(baseHigh_q[15:8], cfgWrData[15:8],
		wrHigh && cfgByteEn[1]), laneMerge(baseHigh_q[7:0],
		cfgWrData[7:0], wrHigh && cfgByteEn[0])};
	assign limitHigh_d = {laneMerge(limitHigh_q[15:8], cfgWrData[31:24],
		wrHigh && cfgByteEn[3]), laneMerge(limitHigh_q[7:0],
		cfgWrData[23:16], wrHigh && cfgByteEn[2])};

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			baseNib_q <= IO_BASE_NIB_RESET;
			limitNib_q <= IO_LIMIT_NIB_RESET;
			baseHigh_q <= IO_HIGH_RESET;
			limitHigh_q <= IO_HIGH_RESET;
		end else begin
			baseNib_q <= baseNib_d;
			limitNib_q <= limitNib_d;
			baseHigh_q <= baseHigh_d;
			limitHigh_q <= limitHigh_d;
		end
	end

	// ------------------------------------------------------------
	// Configuration read back
	// ------------------------------------------------------------
	wire logic [31:0] rdMux;

	// Bytes 1Eh and 1Fh belong to another register and read as zero here.
	assign rdMux = hitLow ? {RD_ZERO[31:16], limitLowByte, baseLowByte} :
		hitHigh ? {limitHigh_q, baseHigh_q} : RD_ZERO;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfgRdData_q <= RD_ZERO;
			cfgRdValid_q <= 1'b0;
		end else begin
			cfgRdData_q <= cfgRead ? rdMux : RD_ZERO;
			cfgRdValid_q <= cfgRead;
		end
	end

	// ------------------------------------------------------------
	// Effective window
	// ------------------------------------------------------------
	wire logic [31:0] windowBase;
	wire logic [31:0] windowLimit;

	assign windowBase = {baseHigh_q, baseNib_q, IO_BASE_FILL};
	assign windowLimit = {limitHigh_q, limitNib_q, IO_LIMIT_FILL};

	// ------------------------------------------------------------
	// Primary and secondary decode
	// ------------------------------------------------------------
	wire logic priInWindow;
	wire logic priClaim;
	wire logic secInWindow;
	wire logic secClaim;

	brio_io_window priWindow (
		.addr(priAddr),
		.windowBase(windowBase),
		.windowLimit(windowLimit),
		.isaEnable(isaEnable),
		.inWindow(priInWindow),
		.claimDown(priClaim)
	);

	brio_io_window secWindow (
		.addr(secAddr),
		.windowBase(windowBase),
		.windowLimit(windowLimit),
		.isaEnable(isaEnable),
		.inWindow(secInWindow),
		.claimDown(secClaim)
	);

	wire logic priFwdIo_d;
	wire logic priFwdMem_d;
	wire logic secFwdIo_d;
	wire logic secFwdMem_d;

	assign priFwdIo_d = priValid && priIsIo && ioEnable &&
		priClaim;
	assign priFwdMem_d = priValid && priIsMem && memEnable &&
		priMemHit;
	// Anything not claimed downstream is a candidate upstream.
	assign secFwdIo_d = secValid && secIsIo && masterEnable &&
		!secClaim;
	assign secFwdMem_d = secValid && secIsMem && masterEnable &&
		!secMemHit;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			priFwdIo_q <= 1'b0;
			priFwdMem_q <= 1'b0;
			secFwdIo_q <= 1'b0;
			secFwdMem_q <= 1'b0;
			priFwdAddr_q <= RD_ZERO;
			secFwdAddr_q <= RD_ZERO;
			ioWindowOn_q <= 1'b1;
		end else begin
			priFwdIo_q <= priFwdIo_d;
			priFwdMem_q <= priFwdMem_d;
			secFwdIo_q <= secFwdIo_d;
			secFwdMem_q <= secFwdMem_d;
			priFwdAddr_q <= priAddr;
			secFwdAddr_q <= secAddr;
			ioWindowOn_q <= windowBase <= windowLimit;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	// Write data as it lands in the base nibble, limit nibble and upper limit field, for the checks below.
	wire logic [3:0] wrBaseNib;
	wire logic [3:0] wrLimitNib;
	wire logic [7:0] wrLimitByte;
	wire logic [15:0] wrLimitHigh;

	assign wrBaseNib = cfgWrData[NIB_HI_MSB:NIB_HI_LSB];
	assign wrLimitByte = cfgWrData[15:8];
	assign wrLimitNib = wrLimitByte[NIB_HI_MSB:NIB_HI_LSB];
	assign wrLimitHigh = cfgWrData[31:16];

	a_pri_io_gate: assert property (@(posedge clk) disable iff (!rst_n)
		!ioEnable |=> !priFwdIo_q)
		else $error("primary I/O forwarded while I/O enable clear");

	a_sec_master_gate: assert property (@(posedge clk)
		disable iff (!rst_n)
		!masterEnable |=> !secFwdIo_q && !secFwdMem_q)
		else $error("secondary traffic forwarded without master enable");

	a_window_off: assert property (@(posedge clk) disable iff (!rst_n)
		windowBase > windowLimit && secValid && secIsIo && masterEnable
		|=> !priFwdIo_q && secFwdIo_q && !ioWindowOn_q)
		else $error("disabled window still decodes");

	a_reset_window: assert property (@(posedge clk)
		disable iff (!rst_n)
		$rose(rst_n) |-> windowBase == RD_ZERO &&
		windowLimit == IO_RESET_LIMIT)
		else $error("window not at reset value after reset");

	a_reset_outputs: assert property (@(posedge clk)
		disable iff (!rst_n)
		$rose(rst_n) |-> !priFwdIo_q && !priFwdMem_q && !secFwdIo_q &&
		!secFwdMem_q && !cfgRdValid_q && ioWindowOn_q)
		else $error("outputs not at reset value after reset");

	a_base_write: assert property (@(posedge clk)
		disable iff (!rst_n)
		wrLow && cfgByteEn[0] |=> windowBase[15:0] ==
		{$past(wrBaseNib), IO_BASE_FILL})
		else $error("base byte write not decoded as bits 15:12");

	a_limit_write: assert property (@(posedge clk)
		disable iff (!rst_n)
		wrLow && cfgByteEn[1] |=> windowLimit[15:0] ==
		{$past(wrLimitNib), IO_LIMIT_FILL})
		else $error("limit byte write not decoded as bits 15:12");

	a_limit_high: assert property (@(posedge clk)
		disable iff (!rst_n)
		wrHigh && cfgByteEn[3] && cfgByteEn[2] |=>
		windowLimit[31:16] == $past(wrLimitHigh))
		else $error("upper limit half did not store write");

	a_cap_nibble: assert property (@(posedge clk)
		disable iff (!rst_n)
		cfgRead && hitLow |=> cfgRdValid_q &&
		cfgRdData_q[3:0] == IO_CAP_NIBBLE &&
		cfgRdData_q[11:8] == IO_CAP_NIBBLE)
		else $error("capability nibble not read as 1h");

	a_high_write: assert property (@(posedge clk)
		disable iff (!rst_n)
		wrHigh && cfgByteEn == 4'hF ##1 cfgRead && hitHigh
		|=> cfgRdData_q == $past(cfgWrData, 2))
		else $error("upper window halves did not store write");

	a_in_window_fwd: assert property (@(posedge clk)
		disable iff (!rst_n)
		priValid && priIsIo && ioEnable && priAddr >= windowBase &&
		priAddr <= windowLimit && windowBase <= windowLimit &&
		(!isaEnable || priAddr[31:16] != ISA_REGION_HIGH)
		|=> priFwdIo_q && priFwdAddr_q == $past(priAddr))
		else $error("in-window primary I/O not forwarded");

	a_isa_hole: assert property (@(posedge clk) disable iff (!rst_n)
		priValid && isaEnable && priAddr[31:16] == ISA_REGION_HIGH &&
		priAddr[ISA_SEL_MSB:ISA_SEL_LSB] != ISA_LOW_QUARTER
		|=> !priFwdIo_q)
		else $error("ISA hole forwarded downstream");

	a_isa_upstream: assert property (@(posedge clk)
		disable iff (!rst_n)
		secValid && secIsIo && isaEnable && masterEnable &&
		secAddr[31:16] == ISA_REGION_HIGH &&
		secAddr[ISA_SEL_MSB:ISA_SEL_LSB] != ISA_LOW_QUARTER
		|=> secFwdIo_q)
		else $error("ISA hole not forwarded upstream");

	a_no_gap: assert property (@(posedge clk) disable iff (!rst_n)
		secValid && secIsIo && masterEnable &&
		(secAddr < windowBase || secAddr > windowLimit)
		|=> secFwdIo_q && secFwdAddr_q == $past(secAddr))
		else $error("out-of-window secondary I/O not forwarded");

	a_sec_in_window: assert property (@(posedge clk)
		disable iff (!rst_n)
		secValid && secIsIo && masterEnable && windowBase <= windowLimit &&
		secAddr >= windowBase && secAddr <= windowLimit &&
		!(isaEnable && secAddr[31:16] == ISA_REGION_HIGH &&
		secAddr[ISA_SEL_MSB:ISA_SEL_LSB] != ISA_LOW_QUARTER)
		|=> !secFwdIo_q)
		else $error("in-window secondary I/O forwarded upstream");

	a_mem_gate: assert property (@(posedge clk)
		disable iff (!rst_n)
		priValid && priIsMem && priMemHit
		|=> priFwdMem_q == $past(memEnable))
		else $error("memory forwarding ignores memory enable");

	a_sec_mem_up: assert property (@(posedge clk)
		disable iff (!rst_n)
		secValid && secIsMem && masterEnable && !secMemHit
		|=> secFwdMem_q && secFwdAddr_q == $past(secAddr))
		else $error("upstream memory not forwarded with master enable");

	a_sec_mem_hit: assert property (@(posedge clk)
		disable iff (!rst_n)
		secValid && secIsMem && secMemHit |=> !secFwdMem_q)
		else $error("downstream memory range forwarded upstream");

endmodule
`default_nettype wire

/* File: tb/brio_bus_model.sv */
// Far-side initiator model that puts requests on the primary or secondary bus.
`timescale 1ns/10ps
`default_nettype none
module brio_bus_model (
	input wire logic clk,
	input wire logic reqValid,
	input wire logic reqSec,
	input wire logic reqIo,
	input wire logic [31:0] reqAddr,
	input wire logic reqHit,
	output logic priValid,
	output logic priIsIo,
	output logic priIsMem,
	output logic [31:0] priAddr,
	output logic priMemHit,
	output logic secValid,
	output logic secIsIo,
	output logic secIsMem,
	output logic [31:0] secAddr,
	output logic secMemHit
);
	logic [31:0] lastAddr_q = 32'h0000_0000;
	wire logic selPri = reqValid & !reqSec;
	wire logic selSec = reqValid & reqSec;

	// An idle bus shows the inverse of the last request address on either bus, never a held value.
	always @(posedge clk) begin
		if (reqValid) begin
			lastAddr_q <= reqAddr;
		end
	end

	assign priValid = selPri;
	assign priIsIo = selPri & reqIo;
	assign priIsMem = selPri & !reqIo;
	assign priAddr = selPri ? reqAddr : ~lastAddr_q;
	assign priMemHit = selPri & reqHit;
	assign secValid = selSec;
	assign secIsIo = selSec & reqIo;
	assign secIsMem = selSec & !reqIo;
	assign secAddr = selSec ? reqAddr : ~lastAddr_q;
	assign secMemHit = selSec & reqHit;
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench of the I/O window decoder and its window registers.
`timescale 1ns/10ps
`default_nettype none
module testbench
	import brio_pkg::*;
;
	logic clk = 0, rst_n = 0, cfgWrite = 0, cfgRead = 0;
	logic [7:0] cfgAddr = 8'h00;
	logic [3:0] cfgByteEn = 4'h0;
	logic [31:0] cfgWrData = 32'h0, reqAddr = 32'h0;
	logic ioEnable = 0, memEnable = 0, masterEnable = 0, isaEnable = 0;
	logic reqValid = 0, reqSec = 0, reqIo = 0, reqHit = 0;
	wire logic priValid, priIsIo, priIsMem, priMemHit;
	wire logic secValid, secIsIo, secIsMem, secMemHit, ioWindowOn_q;
	wire logic [31:0] priAddr, secAddr, cfgRdData_q, priFwdAddr_q, secFwdAddr_q;
	wire logic cfgRdValid_q, priFwdIo_q, priFwdMem_q, secFwdIo_q, secFwdMem_q;
	int n_mismatch = 0, comparisons = 0;

	brio_bus_model brio_bus_model_i (.clk, .reqValid, .reqSec, .reqIo,
		.reqAddr, .reqHit, .priValid, .priIsIo, .priIsMem, .priAddr,
		.priMemHit, .secValid, .secIsIo, .secIsMem, .secAddr, .secMemHit);
	brio_decode brio_decode_i (.clk, .rst_n, .cfgWrite, .cfgRead, .cfgAddr,
		.cfgByteEn, .cfgWrData, .cfgRdData_q, .cfgRdValid_q, .ioEnable,
		.memEnable, .masterEnable, .isaEnable, .priValid, .priIsIo, .priIsMem,
		.priAddr, .priMemHit, .priFwdIo_q, .priFwdMem_q, .priFwdAddr_q,
		.secValid, .secIsIo, .secIsMem, .secAddr, .secMemHit, .secFwdIo_q,
		.secFwdMem_q, .secFwdAddr_q, .ioWindowOn_q);

	initial begin
		forever #25 clk = ~clk;
	end

	// ----------------------------------------------------------
	// Compare, access and closing tasks
	// ----------------------------------------------------------
	task automatic check32(input string what, input logic [31:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic check1(input string what, input logic exp, got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] %s expected %b seen %b", what, exp, got);
		end
	endtask

	// Each task sets all strobes once at a falling edge and leaves them
	// for the next task, so back-to-back calls never drive one twice.
	task automatic cfg_wr(input logic [7:0] a, input logic [3:0] be,
		input logic [31:0] d);
		cfgWrite = 1;
		cfgRead = 0;
		cfgAddr = a;
		cfgByteEn = be;
		cfgWrData = d;
		reqValid = 0;
		@(negedge clk);
	endtask

	task automatic cfg_rd(input logic [7:0] a, input logic [31:0] exp);
		cfgWrite = 0;
		cfgRead = 1;
		cfgAddr = a;
		reqValid = 0;
		@(negedge clk);
		check1("rdValid", 1, cfgRdValid_q);
		check32("rdData", exp, cfgRdData_q);
	endtask

	// One request for one cycle; the claim is looked at in the next cycle.
	task automatic dec(input logic s, io, input logic [31:0] a,
		input logic hit, exp);
		cfgWrite = 0;
		cfgRead = 0;
		reqValid = 1;
		reqSec = s;
		reqIo = io;
		reqAddr = a;
		reqHit = hit;
		@(negedge clk);
		check1("claim", exp, s ? (io ? secFwdIo_q : secFwdMem_q)
			: (io ? priFwdIo_q : priFwdMem_q));
		check32("fwdAddr", a, s ? secFwdAddr_q : priFwdAddr_q);
	endtask

	task automatic idle;
		cfgWrite = 0;
		cfgRead = 0;
		reqValid = 0;
		@(negedge clk);
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		repeat (2000) @(posedge clk);
		n_mismatch++;
		report_and_stop();
	end

	// ----------------------------------------------------------
	// Test sequence
	// ----------------------------------------------------------
	initial begin
		repeat (3) @(negedge clk);
		rst_n = 1;
		check1("windowOn", 1, ioWindowOn_q);
		cfg_rd(OFS_IO_LOW, 32'h0000_0101);
		cfg_rd(OFS_IO_HIGH, 32'h0000_0000);
		cfg_wr(8'h40, 4'hF, 32'hFFFF_FFFF);
		cfg_rd(8'h40, 32'h0000_0000);
		ioEnable = 1;
		masterEnable = 1;
		dec(0, 1, 32'h0000_0FFF, 0, 1);
		dec(0, 1, 32'h0000_1000, 0, 0);
		dec(1, 1, 32'h0000_1000, 0, 1);
		dec(1, 1, 32'h0000_0000, 0, 0);
		$display("test reset_window done");
		ioEnable = 0;
		masterEnable = 0;
		cfg_wr(OFS_IO_LOW, 4'h3, 32'hFFFF_5327);
		cfg_wr(OFS_IO_HIGH, 4'hF, 32'h0001_0001);
		cfg_rd(OFS_IO_LOW, 32'h0000_5121);
		cfg_rd(OFS_IO_HIGH, 32'h0001_0001);
		isaEnable = 1;
		ioEnable = 1;
		masterEnable = 1;
		dec(0, 1, 32'h0001_2000, 0, 1);
		dec(0, 1, 32'h0001_1FFF, 0, 0);
		dec(0, 1, 32'h0001_5FFF, 0, 1);
		dec(0, 1, 32'h0001_6000, 0, 0);
		dec(0, 1, 32'h0001_2300, 0, 1);
		dec(1, 1, 32'h0001_2300, 0, 0);
		$display("test window_bounds done");
		cfg_wr(OFS_IO_HIGH, 4'h3, 32'hFFFF_0000);
		cfg_rd(OFS_IO_HIGH, 32'h0001_0000);
		dec(0, 1, 32'h0000_23FF, 0, 0);
		dec(0, 1, 32'h0000_24FF, 0, 1);
		dec(1, 1, 32'h0000_2200, 0, 1);
		dec(1, 1, 32'h0000_20FF, 0, 0);
		masterEnable = 0;
		dec(1, 1, 32'h0000_2200, 0, 0);
		isaEnable = 0;
		dec(0, 1, 32'h0000_2200, 0, 1);
		$display("test isa_mode done");
		cfg_wr(OFS_IO_HIGH, 4'hF, 32'h0000_0001);
		idle();
		check1("windowOn", 0, ioWindowOn_q);
		masterEnable = 1;
		dec(0, 1, 32'h0000_3000, 0, 0);
		dec(1, 1, 32'h0000_3000, 0, 1);
		$display("test window_off done");
		ioEnable = 0;
		cfg_wr(OFS_IO_HIGH, 4'hF, 32'h0001_0001);
		dec(0, 1, 32'h0001_3000, 0, 0);
		masterEnable = 0;
		dec(1, 1, 32'h0000_0000, 0, 0);
		dec(1, 0, 32'h8000_0000, 0, 0);
		memEnable = 1;
		dec(0, 0, 32'h8000_0000, 1, 1);
		dec(0, 0, 32'h8000_0000, 0, 0);
		masterEnable = 1;
		dec(1, 0, 32'h8000_0000, 0, 1);
		dec(1, 0, 32'h8000_0000, 1, 0);
		dec(1, 1, 32'h0000_0000, 0, 1);
		memEnable = 0;
		dec(0, 0, 32'h8000_0000, 1, 0);
		cfg_wr(OFS_IO_HIGH, 4'hC, 32'h0002_FFFF);
		cfg_rd(OFS_IO_HIGH, 32'h0002_0001);
		$display("test enables done");
		rst_n = 0;
		idle();
		rst_n = 1;
		cfg_rd(OFS_IO_LOW, 32'h0000_0101);
		cfg_rd(OFS_IO_HIGH, 32'h0000_0000);
		$display("test second_reset done");
		report_and_stop();
	end
endmodule
`default_nettype wire
